//--- include/rx_alarm_pkg.sv
// Package of constants for the receive alarm status block
package rx_alarm_pkg;
  localparam logic [10:0] ADDR_STATUS_ONE   = 11'h000;
  localparam logic [10:0] ADDR_STATUS_TWO   = 11'h001;
  localparam logic [10:0] ADDR_STATUS_THREE = 11'h002;
  localparam logic [10:0] ADDR_STATUS_FOUR  = 11'h003;
  // Status one bit positions
  localparam int BIT_B1_PARITY   = 0;
  localparam int BIT_B2_PARITY   = 1;
  localparam int BIT_B3_PARITY   = 2;
  localparam int BIT_CELL_LOST   = 3;
  localparam int BIT_SIGNAL_LOST = 4;
  localparam int BIT_FRAME_MISS  = 5;
  localparam int BIT_FRAME_LOST  = 6;
  localparam int BIT_CARRIER     = 7;
  // Status two bit positions
  localparam int BIT_LINE_AIS    = 0;
  localparam int BIT_LINE_FERF   = 1;
  localparam int BIT_DATA_LOST   = 2;
  localparam int BIT_PTR_LOST    = 3;
  localparam int BIT_PATH_AIS    = 4;
  // Sticky masks: which bits clear on read
  localparam logic [7:0] STICKY_ONE   = 8'h07;
  localparam logic [7:0] STICKY_TWO   = 8'he0;
  localparam logic [7:0] STICKY_THREE = 8'he7;
  localparam logic [7:0] STICKY_FOUR  = 8'h07;
  // Level bits that reset forces set: cell lost, frame missing, frame lost
  localparam logic [7:0] RESET_SET_ONE = 8'h68;
  // Frame and cell counts
  localparam int CELL_SLOT_COUNT  = 7;
  localparam int OOF_SET_FRAMES   = 4;
  localparam int OOF_CLR_FRAMES   = 2;
  localparam int LOS_CLR_PATTERNS = 2;
  localparam int LOF_SET_FRAMES   = 24;
  localparam int LOF_CLR_FRAMES   = 8;
  localparam int PTR_SET_FRAMES   = 8;
  localparam int PTR_CLR_FRAMES   = 3;
  localparam logic [2:0] K2_AIS_CODE  = 3'h7;
  localparam logic [2:0] K2_FERF_CODE = 3'h6;
  localparam logic [3:0] NDF_SET_CODE = 4'h9;
  // Timing
  localparam int CLK_PERIOD_PS   = 40000;
  localparam int LOS_TIME_PS     = 3200000;
  localparam int LOS_CYCLES      = LOS_TIME_PS / CLK_PERIOD_PS;
endpackage : rx_alarm_pkg

//--- rtl/frame_count_filter.sv
// Consecutive-count filter for a level alarm
`timescale 1ns/100ps
module frame_count_filter #(
  parameter int        CW        = 5,
  parameter logic      RESET_VAL = 1'b0
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          soft_reset,
  input  wire logic          sample,
  input  wire logic          bad,
  input  wire logic [CW-1:0] set_count,
  input  wire logic [CW-1:0] clr_count,
  output logic               alarm
);
  typedef struct packed {
    logic          alarm;
    logic [CW-1:0] run;
  } filt_s;
  filt_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (soft_reset) begin
      s_d.alarm = RESET_VAL;
      s_d.run   = '0;
    end else if (sample) begin
      // Count frames disagreeing with the current state
      if (bad != s_q.alarm) begin
        if (s_q.run + 1'b1 >= (s_q.alarm ? clr_count : set_count)) begin
          s_d.alarm = bad;
          s_d.run   = '0;
        end else begin
          s_d.run = s_q.run + 1'b1;
        end
      end else begin
        s_d.run = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{alarm: RESET_VAL, run: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign alarm = s_q.alarm;
endmodule : frame_count_filter

//--- rtl/pin_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] synced
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;
  sync_s s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign synced = s_q.sync;
endmodule : pin_sync

//--- rtl/receive_alarm_status_interrupt.sv
// Receive alarm status registers and interrupt request
// Notes on behaviour
// - Four 8-bit status registers at 000-003
// - Register one: parities, cell, signal, frame, carrier
// - Register two: AIS, FERF, data, pointer, overflows
// - Registers three, four: overflows and path alarms
// - Event bits sticky until their register read
// - Parity error sets bit and interrupt together
// - Cell loss after seven bad, clear seven good
// - Any level alarm change raises the interrupt
// - Reads leave level alarm bits unchanged
// - Any status read releases the interrupt unless a new event or level change arrives in the same cycle
// - Signal loss after 3.2 us without transitions
// - Signal loss clears after two clean framing patterns
// - Frame missing after four bad, clear two good
// - Reset sets cell loss and frame missing
// - Reset clears signal loss
// - Receive stream conditions and the carrier pin set status bits
// - Frame lost after 24 frames, clear after 1 ms
// - Carrier bit follows pin, soft reset ignores it
// - K2 codes 111 and 110, counts one to fifteen
// - Pointer lost after eight bad, clear three good
`timescale 1ns/100ps
module receive_alarm_status_interrupt #(
  parameter int LOS_COUNT = rx_alarm_pkg::LOS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        soft_reset,
  // Controller read port
  input  wire logic [10:0] addr,
  input  wire logic        read_strobe,
  output logic      [7:0]  read_data,
  output logic             read_valid,
  // Receive stream indications, all on clk
  input  wire logic        frame_tick,
  input  wire logic        framing_ok,
  input  wire logic        data_transition,
  input  wire logic        cell_slot_tick,
  input  wire logic        cell_header_ok,
  input  wire logic [2:0]  parity_error,
  input  wire logic        fifo_cell_in,
  input  wire logic        fifo_cell_discard,
  input  wire logic [2:0]  k2_bits,
  input  wire logic        pointer_valid,
  input  wire logic [3:0]  new_data_flag,
  input  wire logic        pointer_all_ones,
  input  wire logic        path_remote_defect,
  input  wire logic        path_far_end_failure,
  input  wire logic        payload_label_mismatch,
  input  wire logic        path_unequipped,
  input  wire logic [2:0]  block_overflow,
  input  wire logic [2:0]  violation_overflow,
  input  wire logic [1:0]  febe_overflow,
  input  wire logic        cell_count_overflow,
  input  wire logic [2:0]  hec_count_overflow,
  input  wire logic [3:0]  ais_set_frames,
  input  wire logic [3:0]  ais_clr_frames,
  input  wire logic [3:0]  ferf_set_frames,
  input  wire logic [3:0]  ferf_clr_frames,
  // Carrier loss pin, asynchronous
  input  wire logic        optical_carrier_lost,
  // Open-drain interrupt, active low
  output logic             interrupt_request_n_o,
  output logic             interrupt_request_n_oe
);
  typedef struct packed {
    logic [3:0][7:0] sticky;
    logic [3:0][7:0] level_prev;
    logic [7:0]      rdata;
    logic            rvalid;
    logic            irq;
    logic [31:0]     los_timer;
    logic            sig_lost;
    logic [1:0]      los_patterns;
    logic            carrier_seen;
  } state_s;
  state_s s_q, s_d;

  logic cell_lost, frame_miss, frame_lost, line_ais, line_ferf;
  logic ptr_lost, path_ais, carrier_sync, ndf_set, data_lost_q;
  logic [3:0][7:0] level_now, view;

  function automatic logic addr_is_status(input logic [10:0] a);
    addr_is_status = (a <= rx_alarm_pkg::ADDR_STATUS_FOUR);
  endfunction : addr_is_status

  // Majority decode of new data flag
  assign ndf_set = ((new_data_flag ~^ rx_alarm_pkg::NDF_SET_CODE) == 4'hf) ||
                   ($countones(new_data_flag ~^ rx_alarm_pkg::NDF_SET_CODE)
                    == 3);

  //--------------------------------------------------------------
  // Level alarm filters
  //--------------------------------------------------------------
  frame_count_filter #(.CW(5), .RESET_VAL(1'b1)) u_cell (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .sample(cell_slot_tick), .bad(!cell_header_ok),
    .set_count(5'(rx_alarm_pkg::CELL_SLOT_COUNT)),
    .clr_count(5'(rx_alarm_pkg::CELL_SLOT_COUNT)),
    .alarm(cell_lost));
  frame_count_filter #(.CW(5), .RESET_VAL(1'b1)) u_oof (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .sample(frame_tick), .bad(!framing_ok),
    .set_count(5'(rx_alarm_pkg::OOF_SET_FRAMES)),
    .clr_count(5'(rx_alarm_pkg::OOF_CLR_FRAMES)),
    .alarm(frame_miss));
  frame_count_filter #(.CW(5), .RESET_VAL(1'b1)) u_lof (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .sample(frame_tick), .bad(frame_miss),
    .set_count(5'(rx_alarm_pkg::LOF_SET_FRAMES)),
    .clr_count(5'(rx_alarm_pkg::LOF_CLR_FRAMES)),
    .alarm(frame_lost));
  frame_count_filter #(.CW(4), .RESET_VAL(1'b0)) u_ais (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .sample(frame_tick), .bad(k2_bits == rx_alarm_pkg::K2_AIS_CODE),
    .set_count(ais_set_frames), .clr_count(ais_clr_frames),
    .alarm(line_ais));
  frame_count_filter #(.CW(4), .RESET_VAL(1'b0)) u_ferf (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .sample(frame_tick), .bad(k2_bits == rx_alarm_pkg::K2_FERF_CODE),
    .set_count(ferf_set_frames), .clr_count(ferf_clr_frames),
    .alarm(line_ferf));
  frame_count_filter #(.CW(4), .RESET_VAL(1'b0)) u_path_alarm_indication (
    .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .sample(frame_tick), .bad(pointer_all_ones),
    .set_count(4'(rx_alarm_pkg::PTR_CLR_FRAMES)),
    .clr_count(4'(rx_alarm_pkg::PTR_CLR_FRAMES)),
    .alarm(path_ais));
  frame_count_filter #(.CW(4), .RESET_VAL(1'b0)) u_lop (
    .clk(clk), .reset_n(reset_n),
    .soft_reset(soft_reset || path_ais),
    .sample(frame_tick), .bad(!pointer_valid || ndf_set),
    .set_count(4'(rx_alarm_pkg::PTR_SET_FRAMES)),
    .clr_count(4'(rx_alarm_pkg::PTR_CLR_FRAMES)),
    .alarm(ptr_lost));

  pin_sync #(.W(1)) u_carrier (
    .clk(clk), .reset_n(reset_n),
    .pin(optical_carrier_lost), .synced(carrier_sync));

  // Receive data loss level: set on discard, clear on accepted cell
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_lost_q <= 1'b0;
    end else if (soft_reset) begin
      data_lost_q <= 1'b0;
    end else if (fifo_cell_discard) begin
      data_lost_q <= 1'b1;
    end else if (fifo_cell_in) begin
      data_lost_q <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // Register view
  //--------------------------------------------------------------
  always_comb begin
    level_now    = '0;
    level_now[0] = {carrier_sync, frame_lost, frame_miss, s_q.sig_lost,
                    cell_lost, 3'h0};
    level_now[1] = {3'h0, path_ais, ptr_lost, data_lost_q, line_ferf,
                    line_ais};
    level_now[2] = {3'h0, path_far_end_failure, path_remote_defect,
                    3'h0};
    level_now[3] = {3'h0, path_unequipped, payload_label_mismatch,
                    3'h0};
    for (int i = 0; i < 4; i++) begin
      view[i] = level_now[i] | s_q.sticky[i];
    end
  end

  //--------------------------------------------------------------
  // State update
  //--------------------------------------------------------------
  always_comb begin
    logic [3:0][7:0] ev;
    logic            any_rd;
    logic            cause;
    ev     = '0;
    any_rd = read_strobe && addr_is_status(addr);
    s_d    = s_q;
    // Only receive stream inputs feed these events
    ev[0]  = {5'h00, parity_error};
    ev[1]  = {block_overflow, 5'h00};
    ev[2]  = {cell_count_overflow, febe_overflow, 2'h0,
              violation_overflow};
    ev[3]  = {5'h00, hec_count_overflow};

    s_d.rvalid = read_strobe;
    s_d.rdata  = addr_is_status(addr) ? view[addr[1:0]] : 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (any_rd && addr[1:0] == 2'(i)) begin
        s_d.sticky[i] = ev[i];
      end else begin
        s_d.sticky[i] = s_q.sticky[i] | ev[i];
      end
    end

    s_d.level_prev = level_now;
    cause = (level_now != s_q.level_prev) || (|ev);
    if (cause) begin
      s_d.irq = 1'b1;
    end else if (any_rd) begin
      s_d.irq = 1'b0;
    end

    // Signal loss timing
    if (data_transition) begin
      s_d.los_timer = '0;
    end else if (s_q.los_timer < 32'(LOS_COUNT)) begin
      s_d.los_timer = s_q.los_timer + 32'd1;
    end
    if (!data_transition && s_q.los_timer + 32'd1 >= 32'(LOS_COUNT)) begin
      s_d.sig_lost     = 1'b1;
      s_d.los_patterns = '0;
    end else if (s_q.sig_lost && frame_tick && framing_ok) begin
      if (s_q.los_patterns + 2'd1 >= 2'(rx_alarm_pkg::LOS_CLR_PATTERNS))
      begin
        s_d.sig_lost     = 1'b0;
        s_d.los_patterns = '0;
      end else begin
        s_d.los_patterns = s_q.los_patterns + 2'd1;
      end
    end
    s_d.carrier_seen = carrier_sync;

    if (soft_reset) begin
      s_d.sticky       = '0;
      s_d.sig_lost     = 1'b0;
      s_d.los_timer    = '0;
      s_d.los_patterns = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.level_prev[0] <= rx_alarm_pkg::RESET_SET_ONE;
    end else begin
      s_q <= s_d;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign read_data              = s_q.rdata;
  assign read_valid             = s_q.rvalid;
  assign interrupt_request_n_o  = 1'b0;
  assign interrupt_request_n_oe = s_q.irq;
endmodule : receive_alarm_status_interrupt

//--- tb/rx_alarm_properties.sv
// Port checks for the receive alarm status block
`timescale 1ns/100ps
module rx_alarm_properties #(
  parameter int LOS_COUNT = 80
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        soft_reset,
  input wire logic [10:0] addr,
  input wire logic        read_strobe,
  input wire logic [7:0]  read_data,
  input wire logic        read_valid,
  input wire logic        data_transition,
  input wire logic [2:0]  parity_error,
  input wire logic        optical_carrier_lost,
  input wire logic        interrupt_request_n_o,
  input wire logic        interrupt_request_n_oe
);
  logic [15:0] quiet_q;
  logic        pend_q;
  wire         rd0 = read_strobe && addr == 11'h000;
  // ----
  // Quiet time and pending parity event
  // ----
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_q <= 16'h0000;
      pend_q  <= 1'b0;
    end else begin
      quiet_q <= (data_transition || soft_reset) ? 16'h0000
               : quiet_q + 16'(quiet_q != 16'hffff);
      pend_q  <= !soft_reset && (parity_error[0] || (pend_q && !rd0));
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (read_strobe |=> read_valid)
    else $error("read strobe without answer");
  a_unmapped_zero: assert property (read_strobe && addr > 11'h003 |=>
    read_data == 8'h00) else $error("unmapped read not zero");
  a_parity_irq: assert property (|parity_error |=>
    interrupt_request_n_oe) else $error("parity without interrupt");
  a_event_kept: assert property (pend_q && rd0 && !soft_reset |=>
    read_data[0])
    else $error("parity event lost");
  a_carrier_irq: assert property ($changed(optical_carrier_lost) |->
    ##[1:5] interrupt_request_n_oe) else $error("carrier change silent");
  a_irq_hold: assert property (interrupt_request_n_oe && !read_strobe &&
    !soft_reset |=> interrupt_request_n_oe) else $error("interrupt dropped");
  a_los_set: assert property (int'(quiet_q) > LOS_COUNT + 2 && rd0 |=>
    read_data[4]) else $error("signal loss not set");
  a_pin_low: assert property (interrupt_request_n_oe |->
    !interrupt_request_n_o) else $error("interrupt pin not low");
  a_soft_level: assert property (soft_reset ##[1:4] (rd0 && !soft_reset)
    |=> (read_data & 8'h58) == 8'h48) else $error("soft reset levels");
  c_read: cover property (rd0 && read_data[3]);
  c_parity: cover property (pend_q && rd0);
  c_carrier: cover property ($rose(optical_carrier_lost));
endmodule : rx_alarm_properties

bind receive_alarm_status_interrupt rx_alarm_properties #(
  .LOS_COUNT(LOS_COUNT)
) i_props (.clk, .reset_n, .soft_reset, .addr, .read_strobe, .read_data,
  .read_valid, .data_transition, .parity_error, .optical_carrier_lost,
  .interrupt_request_n_o, .interrupt_request_n_oe);

//--- tb/host_reader.sv
// Host model reading the status registers
`timescale 1ns/100ps
module host_reader (
  input  wire logic        clk,
  input  wire logic [7:0]  read_data,
  input  wire logic        read_valid,
  output logic      [10:0] addr,
  output logic             read_strobe
);
  logic [7:0] got [4];
  initial begin
    addr        = 11'h000;
    read_strobe = 1'b0;
  end
  // Consecutive reads of n registers starting at first
  task automatic read_regs(input logic [10:0] first, input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      addr        = first + 11'(k);
      read_strobe = 1'b1;
      @(negedge clk);
      read_strobe = 1'b0;
      got[k]      = read_valid ? read_data : 8'hxx;
    end
  endtask : read_regs
endmodule : host_reader

//--- tb/receive_alarm_status_interrupt_bench.sv
// Self-checking bench for the receive alarm status block
`timescale 1ns/100ps
module receive_alarm_status_interrupt_bench;
  logic        clk, reset_n, soft_reset, dtr, ftick, fok, ctick, cok;
  logic        fin, fdis, opt, read_strobe, read_valid, irq_o, irq_oe;
  logic [14:0] ev;
  logic [2:0]  k2;
  logic [3:0]  lv, fc;
  logic [10:0] addr;
  logic [7:0]  read_data;
  logic [7:0]  seen;
  logic [7:0]  stk [4];
  logic [7:0]  rows [15];
  int          bad_count, checks_done;

  receive_alarm_status_interrupt i_dut (
    .clk, .reset_n, .soft_reset, .addr, .read_strobe, .read_data,
    .read_valid, .frame_tick(ftick), .framing_ok(fok),
    .data_transition(dtr), .cell_slot_tick(ctick), .cell_header_ok(cok),
    .parity_error(ev[2:0]), .fifo_cell_in(fin), .fifo_cell_discard(fdis),
    .k2_bits(k2), .pointer_valid(1'b1), .new_data_flag(4'h6),
    .pointer_all_ones(1'b0), .path_remote_defect(lv[0]),
    .path_far_end_failure(lv[1]), .payload_label_mismatch(lv[2]),
    .path_unequipped(lv[3]), .block_overflow(ev[5:3]),
    .violation_overflow(ev[8:6]), .febe_overflow(ev[10:9]),
    .cell_count_overflow(ev[11]), .hec_count_overflow(ev[14:12]),
    .ais_set_frames(fc), .ais_clr_frames(fc), .ferf_set_frames(fc),
    .ferf_clr_frames(fc), .optical_carrier_lost(opt),
    .interrupt_request_n_o(irq_o), .interrupt_request_n_oe(irq_oe));
  host_reader i_host (.clk, .read_data, .read_valid, .addr, .read_strobe);

  task automatic check(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic summarize;
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic rd(input logic [10:0] a, input int n);
    i_host.read_regs(a, n);
  endtask : rd
  task automatic bit0(input string n, input int b, input logic v);
    rd(11'h000, 1);
    check(n, 8'(i_host.got[0][b]), 8'(v));
  endtask : bit0
  // Frame or cell slot pulse
  task automatic slot(input logic f, input logic ok);
    if (f) begin
      fok   = ok;
      ftick = 1'b1;
    end else begin
      cok   = ok;
      ctick = 1'b1;
    end
    tick(1);
    ftick = 1'b0;
    ctick = 1'b0;
    tick(1);
  endtask : slot

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {reset_n, soft_reset, ftick, fok, ctick, cok, fin, fdis, opt} = '0;
    {ev, k2, lv} = '0;
    dtr  = 1'b1;
    fc   = 4'h1;
    stk  = '{rx_alarm_pkg::STICKY_ONE, rx_alarm_pkg::STICKY_TWO,
             rx_alarm_pkg::STICKY_THREE, rx_alarm_pkg::STICKY_FOUR};
    rows = '{8'h00, 8'h01, 8'h02, 8'h15, 8'h16, 8'h17, 8'h20, 8'h21,
             8'h22, 8'h25, 8'h26, 8'h27, 8'h30, 8'h31, 8'h32};
    tick(16);
    reset_n = 1'b1;
    tick(2);
    for (int i = 0; i < 15; i++) begin
      ev = 15'h0001 << i;
      tick(1);
      ev = '0;
      tick(1);
      check("irq", 8'(irq_oe), 8'h01);
      rd(11'(rows[i][5:4]), 1);
      seen = i_host.got[0];
      rd(11'(rows[i][5:4]), 1);
      check("evt", seen & stk[rows[i][5:4]],
            8'h01 << rows[i][2:0]);
      check("clr", i_host.got[0] & stk[rows[i][5:4]], 8'h00);
      check("rel", 8'(irq_oe), 8'h00);
    end
    rd(11'h000, 4);
    check("reg0", i_host.got[0], 8'h68);
    check("reg1", i_host.got[1] | i_host.got[2] | i_host.got[3], 8'h00);
    rd(11'h006, 1);
    check("unmapped", i_host.got[0], 8'h00);
    bit0("level", 3, 1'b1);
    fork
      rd(11'h000, 1);
      begin
        @(negedge clk);
        ev = 15'h0001;
        tick(1);
        ev = '0;
      end
    join
    check("coin_irq", 8'(irq_oe), 8'h01);
    bit0("coin", 0, 1'b1);
    repeat (6) slot(1'b0, 1'b1);
    bit0("cell6", 3, 1'b1);
    slot(1'b0, 1'b1);
    check("cell_irq", 8'(irq_oe), 8'h01);
    bit0("cell7", 3, 1'b0);
    repeat (7) slot(1'b0, 1'b0);
    bit0("cellbad", 3, 1'b1);
    slot(1'b1, 1'b1);
    bit0("oof1", 5, 1'b1);
    slot(1'b1, 1'b1);
    bit0("oof2", 5, 1'b0);
    repeat (4) slot(1'b1, 1'b0);
    bit0("oof4", 5, 1'b1);
    k2 = 3'h7;
    slot(1'b1, 1'b1);
    rd(11'h001, 1);
    check("ais", i_host.got[0] & 8'h03, 8'h01);
    k2 = 3'h6;
    slot(1'b1, 1'b1);
    rd(11'h001, 1);
    check("ferf", i_host.got[0] & 8'h03, 8'h02);
    dtr = 1'b0;
    tick(90);
    bit0("los", 4, 1'b1);
    dtr = 1'b1;
    repeat (2) slot(1'b1, 1'b1);
    bit0("los_clr", 4, 1'b0);
    opt = 1'b1;
    tick(4);
    bit0("carrier", 7, 1'b1);
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(1);
    rd(11'h000, 1);
    check("soft", i_host.got[0], 8'he8);
    lv   = 4'hf;
    fdis = 1'b1;
    tick(1);
    fdis = 1'b0;
    tick(2);
    rd(11'h001, 3);
    check("dlost", i_host.got[0] & 8'h04, 8'h04);
    check("path3", i_host.got[1] & 8'h18, 8'h18);
    check("path4", i_host.got[2] & 8'h18, 8'h18);
    fin = 1'b1;
    tick(1);
    fin = 1'b0;
    tick(2);
    rd(11'h001, 1);
    check("dfound", i_host.got[0] & 8'h04, 8'h00);
    summarize();
  end
endmodule : receive_alarm_status_interrupt_bench
